// *** design/pack_seq_pkg.sv ***
/*
  Shared constants and types of the pack power-up sequencer: state codes,
  reset values, timing figures and the packed carriers between blocks.
  Assumes a single 250 MHz clock and a nonvolatile store outside the block.
*/
package pack_seq_pkg;

  localparam int          NUM_CELLS       = 8;
  localparam logic [7:0]  CELL_MAP_RESET  = 8'h83;   // Three cells: 1, 2 and 8
  localparam logic [11:0] CELL_ZERO_CODE  = 12'h000;

  // Timing figures in their printed units
  localparam int          CLK_KHZ         = 250000;
  localparam int          SCAN_PERIOD_MS  = 32;
  localparam int          LOAD_SETTLE_MS  = 3000;
  localparam int          LOAD_SAMPLE_MS  = 256;
  localparam int          NO_LOAD_NEEDED  = 2;

  // Derived cycle counts
  localparam int          SCAN_PERIOD_CYC = SCAN_PERIOD_MS * CLK_KHZ;
  localparam int          LOAD_SETTLE_CYC = LOAD_SETTLE_MS * CLK_KHZ;
  localparam int          LOAD_SAMPLE_CYC = LOAD_SAMPLE_MS * CLK_KHZ;

  // Synchronised pin positions
  localparam int          PIN_CHARGER     = 0;
  localparam int          PIN_LOAD        = 1;
  localparam int          PIN_VDD_1V      = 2;
  localparam int          PIN_VDD_POR     = 3;
  localparam int          PIN_RGO_OK      = 4;
  localparam int          NUM_PINS        = 5;

  typedef enum logic [2:0] {
    ST_PWR_DOWN  = 3'b000,
    ST_RELOAD    = 3'b001,
    ST_POR_LOOP  = 3'b010,
    ST_LOAD_WAIT = 3'b011,
    ST_LOAD_SAMP = 3'b100,
    ST_NORMAL    = 3'b101
  } seq_state_t;

  // One converted cell reading from the measurement front end
  typedef struct packed {
    logic        done;
    logic [11:0] voltage;
    logic        openWireFail;
    logic        inLimits;
  } cell_sample_t;

  // Analog supply comparator levels as seen on the pins
  typedef struct packed {
    logic vddAbove1v;
    logic vddAbovePor;
    logic regulatorOutputOk;
  } supply_t;

endpackage

// *** design/interval_timer.sv ***
/*
  Free-running interval timer giving a one-cycle tick each period, with a
  synchronous restart. Assumes the period is at least two cycles.
*/
`timescale 1ns/100ps
module interval_timer
  import pack_seq_pkg::*;
#(
  parameter int PERIOD = SCAN_PERIOD_CYC
)(
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic restart,
  output logic      tick
);

  logic [31:0] count;
  wire  logic  atEnd = (count == 32'(PERIOD - 1));

  // Count up, wrap and pulse at the end of each period
  always_ff @(posedge mclk)
  begin
    if (!rst_b || restart)
    begin
      count <= 32'h0000_0000;
      tick  <= 1'b0;
    end
    else
    begin
      count <= atEnd ? 32'h0000_0000 : count + 32'h0000_0001;
      tick  <= atEnd;
    end
  end

endmodule

// *** design/cell_scanner.sv ***
/*
  Walks the eight cell inputs once per start pulse, measuring only the
  fitted ones. Assumes the front end answers each request with done.
*/
`timescale 1ns/100ps
module cell_scanner
  import pack_seq_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic         start,
  input  wire logic [7:0]   cellMap,
  input  wire cell_sample_t sample,
  output logic [2:0]        cellSelect,
  output logic              sampleReq,
  output logic              busy,
  output logic              scanDone,
  output logic              scanFault
);

  logic        fault;
  wire  logic  fitted  = cellMap[cellSelect];
  wire  logic  lastPos = (cellSelect == 3'h7);
  // Zero reading, failed open-wire test or reading out of limits
  wire  logic  bad     = (sample.voltage == CELL_ZERO_CODE) || sample.openWireFail
                         || !sample.inLimits;
  wire  logic  stepOn  = busy && (!fitted || (sampleReq && sample.done));

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      cellSelect <= 3'h0;
      sampleReq  <= 1'b0;
      busy       <= 1'b0;
      scanDone   <= 1'b0;
      scanFault  <= 1'b0;
      fault      <= 1'b0;
    end
    else
    begin
      scanDone <= 1'b0;
      if (start && !busy)
      begin
        busy       <= 1'b1;
        cellSelect <= 3'h0;
        fault      <= 1'b0;
      end
      else if (stepOn)
      begin
        sampleReq <= 1'b0;
        if (fitted && bad)
          fault <= 1'b1;
        if (lastPos)
        begin
          busy      <= 1'b0;
          scanDone  <= 1'b1;
          scanFault <= fault || (fitted && bad);
        end
        else
          cellSelect <= cellSelect + 3'h1;
      end
      else if (busy && fitted)
        sampleReq <= 1'b1;
    end
  end

endmodule

// *** design/pack_power_up_sequencer.sv ***
/*
  Power-on sequencer of a multi-cell pack monitor: power-down hold,
  nonvolatile reload, reset-loop scanning, timed load check and FET enable.
  Assumes comparator and charger/load pins are asynchronous, the measurement
  front end and nonvolatile store run on mclk, and the clock runs whenever
  the regulator is up.
*/
`timescale 1ns/100ps
module pack_power_up_sequencer
  import pack_seq_pkg::*;
#(
  parameter int SCAN_CYC   = SCAN_PERIOD_CYC,
  parameter int SETTLE_CYC = LOAD_SETTLE_CYC,
  parameter int SAMPLE_CYC = LOAD_SAMPLE_CYC
)(
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic         chargerMonitorInput,
  input  wire logic         loadMonitorInput,
  input  wire supply_t      supplyLevels,
  input  wire cell_sample_t sample,
  input  wire logic         tempOk,
  input  wire logic         overcurrentFault,
  input  wire logic         nvReloadDone,
  input  wire logic [7:0]   nvCellMap,
  input  wire logic         mapWrite,
  input  wire logic [7:0]   mapWriteData,
  input  wire logic [7:0]   balanceRequest,
  output logic [7:0]        cell_presence_map,
  output logic [7:0]        balanceEnable,
  output logic [2:0]        cellSelect,
  output logic              sampleReq,
  output logic              internalSupplyEn,
  output logic              nvReloadReq,
  output logic              fetEnable,
  output logic              loadCheckPassed,
  output logic              scanError,
  output seq_state_t        seqState
);

  // Pin synchronisers
  logic [NUM_PINS-1:0] pinRaw;
  logic [NUM_PINS-1:0] pinMeta;
  logic [NUM_PINS-1:0] pinSync;

  assign pinRaw = {supplyLevels.regulatorOutputOk, supplyLevels.vddAbovePor,
                   supplyLevels.vddAbove1v, loadMonitorInput, chargerMonitorInput};

  // Two flops per pin; only the second stage is ever read
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g = g + 1)
    begin : gen_sync
      always_ff @(posedge mclk)
      begin
        if (!rst_b)
        begin
          pinMeta[g] <= 1'b0;
          pinSync[g] <= 1'b0;
        end
        else
        begin
          pinMeta[g] <= pinRaw[g];
          pinSync[g] <= pinMeta[g];
        end
      end
    end
  endgenerate

  wire logic chargerSeen = pinSync[PIN_CHARGER];
  wire logic loadSeen    = pinSync[PIN_LOAD];
  wire logic vdd1vOk     = pinSync[PIN_VDD_1V];
  wire logic vddPorOk    = pinSync[PIN_VDD_POR];
  wire logic rgoOk       = pinSync[PIN_RGO_OK];

  // Supply loss: a dip of any length is ridden out while the regulator holds
  // and VDD stays above 1 V; a sag below the reset threshold with
  // the regulator also low drops the part back to power-down.
  wire logic supplyLoss  = (!vddPorOk && !rgoOk)
                           || !vdd1vOk;

  // Working state
  seq_state_t  state;
  seq_state_t  next_state;
  logic [31:0] loadCount;
  logic [1:0]  noLoadCount;
  logic        scanValid;

  // Scan timing and cell walker
  logic scanTick;
  logic scanBusy;
  logic scanDone;
  logic scanFault;
  wire  logic awake = (state != ST_PWR_DOWN) && (state != ST_RELOAD);

  // Scan period restarts while asleep so the first scan follows wake-up
  interval_timer #(
    .PERIOD (SCAN_CYC)
  ) u_scan_timer (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .restart (!awake),
    .tick    (scanTick)
  );

  cell_scanner u_scanner (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .start      (scanTick && awake),
    .cellMap    (cell_presence_map),
    .sample     (sample),
    .cellSelect (cellSelect),
    .sampleReq  (sampleReq),
    .busy       (scanBusy),
    .scanDone   (scanDone),
    .scanFault  (scanFault)
  );

  // A completed scan is clean only if cells and temperatures are in range
  wire logic scanClean = scanDone && !scanFault && tempOk;
  wire logic scanBad   = (scanDone && (scanFault || !tempOk))
                         || (!tempOk && state != ST_NORMAL);

  // Load-check timing
  wire logic settleEnd  = (loadCount == 32'(SETTLE_CYC - 1));
  wire logic sampleEnd  = (loadCount == 32'(SAMPLE_CYC - 1));
  wire logic lastNoLoad = (noLoadCount == 2'(NO_LOAD_NEEDED - 1));
  wire logic loadBad    = scanBad || (state == ST_LOAD_SAMP && sampleEnd && loadSeen);

  // Sequencer transitions
  always_comb
  begin
    next_state = state;
    case (state)
      ST_PWR_DOWN:
        if (chargerSeen && !supplyLoss)
          next_state = ST_RELOAD;
      ST_RELOAD:
        if (nvReloadDone)
          next_state = ST_POR_LOOP;
      ST_POR_LOOP:
        if (scanValid)
          next_state = ST_LOAD_WAIT;
      ST_LOAD_WAIT:
        if (loadBad)
          next_state = ST_POR_LOOP;
        else if (settleEnd)
          next_state = ST_LOAD_SAMP;
      ST_LOAD_SAMP:
        if (loadBad)
          next_state = ST_POR_LOOP;
        else if (sampleEnd && lastNoLoad)
          next_state = ST_NORMAL;
      ST_NORMAL:
        next_state = ST_NORMAL;
      default:
        next_state = ST_PWR_DOWN;
    endcase
    if (supplyLoss)
      next_state = ST_PWR_DOWN;
  end

  // State register; reset is the first supply connection
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      state <= ST_PWR_DOWN;
    else
      state <= next_state;
  end

  // Result of the latest scan, held between scans only in the loop; a bad scan while in
  // the loop simply waits for the next 32 ms tick to try again.
  always_ff @(posedge mclk)
  begin
    if (!rst_b || !awake)
      scanValid <= 1'b0;
    else if (scanBad)
      scanValid <= 1'b0;
    else if (scanClean)
      scanValid <= 1'b1;
    else if (state != ST_POR_LOOP)
      scanValid <= 1'b0;
  end

  // Load timer: settle period, then one 256 ms window per sample
  always_ff @(posedge mclk)
  begin
    if (!rst_b || loadBad || next_state != state)
      loadCount <= 32'h0000_0000;
    else if (state == ST_LOAD_SAMP && sampleEnd)
      loadCount <= 32'h0000_0000;
    else if (state == ST_LOAD_WAIT || state == ST_LOAD_SAMP)
      loadCount <= loadCount + 32'h0000_0001;
  end

  // Consecutive no-load samples; a load seen at a sample end starts over
  always_ff @(posedge mclk)
  begin
    if (!rst_b || loadBad || state != ST_LOAD_SAMP)
      noLoadCount <= 2'h0;
    else if (sampleEnd && !loadSeen)
      noLoadCount <= noLoadCount + 2'h1;
  end

  // Presence map: reloaded from the store, writable afterwards. The
  // write port is ignored during the reload so the stored copy wins.
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      cell_presence_map <= CELL_MAP_RESET;
    else if (state == ST_RELOAD && nvReloadDone)
      cell_presence_map <= nvCellMap;
    else if (mapWrite && state != ST_RELOAD)
      cell_presence_map <= mapWriteData;
  end

  // Reload request stands for the whole reload state
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      nvReloadReq <= 1'b0;
    else
      nvReloadReq <= (next_state == ST_RELOAD);
  end

  // Internal supplies follow wake-up; off while held in power-down
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      internalSupplyEn <= 1'b0;
    else
      internalSupplyEn <= (next_state != ST_PWR_DOWN);
  end

  // Load check passes once on entry to normal, cleared by power loss
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      loadCheckPassed <= 1'b0;
    else if (next_state == ST_NORMAL && state != ST_NORMAL)
      loadCheckPassed <= 1'b1;
    else if (next_state != ST_NORMAL)
      loadCheckPassed <= 1'b0;
  end

  // Cell health seen in normal monitoring; refreshed each scan
  logic cellsGood;
  always_ff @(posedge mclk)
  begin
    if (!rst_b || state != ST_NORMAL)
      cellsGood <= 1'b1;
    else if (scanDone)
      cellsGood <= !scanFault;
  end

  // FET drive: only in normal, with every condition met. The check on
  // next_state keeps the enable low on the edge that leaves normal.
  wire logic fetOk = (state == ST_NORMAL) && (next_state == ST_NORMAL) && cellsGood
                     && !(scanDone && scanFault) && tempOk && !overcurrentFault
                     && loadCheckPassed;
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      fetEnable <= 1'b0;
    else
      fetEnable <= fetOk;
  end

  // Balancing is only allowed on fitted positions and in normal
  genvar b;
  generate
    for (b = 0; b < NUM_CELLS; b = b + 1)
    begin : gen_bal
      always_ff @(posedge mclk)
      begin
        if (!rst_b)
          balanceEnable[b] <= 1'b0;
        else
          balanceEnable[b] <= balanceRequest[b] && cell_presence_map[b]
                              && (state == ST_NORMAL);
      end
    end
  endgenerate

  // Status outputs
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      scanError <= 1'b0;
      seqState  <= ST_PWR_DOWN;
    end
    else
    begin
      scanError <= awake && !scanValid && (state == ST_POR_LOOP);
      seqState  <= next_state;
    end
  end

endmodule

// *** testbench/pack_power_up_sequencer_asserts.sv ***
/*
  Port checks of the pack power-up sequencer.
  Assumes binding onto the top module, one clock.
*/
`timescale 1ns/100ps
module pack_power_up_sequencer_asserts
  import pack_seq_pkg::*;
(
  input wire logic         mclk,
  input wire logic         rst_b,
  input wire logic         chargerMonitorInput,
  input wire logic         loadMonitorInput,
  input wire supply_t      supplyLevels,
  input wire cell_sample_t sample,
  input wire logic         tempOk,
  input wire logic         overcurrentFault,
  input wire logic         nvReloadDone,
  input wire logic [7:0]   nvCellMap,
  input wire logic         mapWrite,
  input wire logic [7:0]   mapWriteData,
  input wire logic [7:0]   balanceRequest,
  input wire logic [7:0]   cell_presence_map,
  input wire logic [7:0]   balanceEnable,
  input wire logic [2:0]   cellSelect,
  input wire logic         sampleReq,
  input wire logic         internalSupplyEn,
  input wire logic         nvReloadReq,
  input wire logic         fetEnable,
  input wire logic         loadCheckPassed,
  input wire logic         scanError,
  input wire seq_state_t   seqState
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // Pins pass two sync flops: a wake cause held three samples is seen at
  // the third, so the state must still be asleep there to make a match
  sequence s_wake;
    (chargerMonitorInput && supplyLevels == 3'h7)[*3] ##0 seqState == ST_PWR_DOWN;
  endsequence
  sequence s_reloadEnd;
    (supplyLevels == 3'h7)[*4] ##0 (seqState == ST_RELOAD && nvReloadDone);
  endsequence

  property p_reset_state;
    !$past(rst_b) |-> seqState == ST_PWR_DOWN && !fetEnable;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("not asleep after reset");
  property p_map_default;
    !$past(rst_b) |-> cell_presence_map == CELL_MAP_RESET;
  endproperty
  a_map_default: assert property (p_map_default) else $error("map reset value");
  property p_wake;
    s_wake |=> seqState == ST_RELOAD && internalSupplyEn;
  endproperty
  a_wake: assert property (p_wake) else $error("charger did not wake");
  property p_reload;
    s_reloadEnd |=> seqState == ST_POR_LOOP && cell_presence_map == $past(nvCellMap);
  endproperty
  a_reload: assert property (p_reload) else $error("reload not taken");
  property p_reload_req;
    nvReloadReq |-> seqState == ST_RELOAD && internalSupplyEn;
  endproperty
  a_reload_req: assert property (p_reload_req) else $error("reload request outside reload");
  property p_fitted_only;
    sampleReq |-> cell_presence_map[cellSelect];
  endproperty
  a_fitted_only: assert property (p_fitted_only) else $error("absent cell measured");
  property p_balance;
    $past(rst_b) |-> balanceEnable == ($past(balanceRequest) & $past(cell_presence_map)
      & {8{$past(seqState) == ST_NORMAL}});
  endproperty
  a_balance: assert property (p_balance) else $error("balance gate wrong");
  property p_fet_gate;
    fetEnable |-> seqState == ST_NORMAL && $past(tempOk) && !$past(overcurrentFault);
  endproperty
  a_fet_gate: assert property (p_fet_gate) else $error("fets on too early");
  property p_normal_entry;
    $rose(seqState == ST_NORMAL) |-> $past(seqState) == ST_LOAD_SAMP;
  endproperty
  a_normal_entry: assert property (p_normal_entry) else $error("normal without load check");
  property p_dip;
    (!supplyLevels.vddAbovePor && !supplyLevels.regulatorOutputOk)[*4]
      |=> seqState == ST_PWR_DOWN && !fetEnable;
  endproperty
  a_dip: assert property (p_dip) else $error("no power-down on low supply");
  property p_dip_1v;
    (!supplyLevels.vddAbove1v)[*4] |=> seqState == ST_PWR_DOWN;
  endproperty
  a_dip_1v: assert property (p_dip_1v) else $error("no power-down below 1 V");
endmodule

// *** testbench/cell_stack_model.sv ***
/*
  Cell stack, converter and nonvolatile store beside the sequencer.
  Assumes requests are held until answered, as the sequencer does.
*/
`timescale 1ns/100ps
module cell_stack_model
  import pack_seq_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       slow,
  input  wire logic [7:0] fitted,
  input  wire logic [2:0] cellSelect,
  input  wire logic       sampleReq,
  input  wire logic       nvReloadReq,
  input  wire logic [7:0] storedMap,
  output cell_sample_t    sample,
  output logic            nvReloadDone,
  output logic [7:0]      nvCellMap
);
  int          waitCnt = 0;
  logic [11:0] noise   = 12'hA5A;

  // Between answers the bus shows junk, never the last reading
  always @(posedge mclk)
  begin
    noise <= ~noise + 12'h001;
    sample <= {1'b0, noise, noise[0], noise[1]};
    if (sampleReq && !sample.done)
    begin
      waitCnt <= waitCnt + 1;
      if (waitCnt >= (slow ? 6 : 0))
      begin
        waitCnt <= 0;
        sample <= {1'b1, fitted[cellSelect] ? 12'hC80 : CELL_ZERO_CODE, 1'b0, 1'b1};
      end
    end
    nvReloadDone <= nvReloadReq && !nvReloadDone;
    nvCellMap <= nvReloadReq ? storedMap : ~storedMap;
  end
endmodule

// *** testbench/pack_power_up_sequencer_tb_top.sv ***
/*
  Self-checking bench of the pack power-up sequencer with short timers.
  Assumes the cell stack model answers cell and store requests.
*/
`timescale 1ns/100ps
module pack_power_up_sequencer_tb_top
  import pack_seq_pkg::*;
;
  // Scan period above the slowest full walk (eight slow cells)
  localparam int SCAN = 128, SETTLE = 100, SAMPLE = 20;
  logic         mclk, rst_b, chargerMonitorInput, loadMonitorInput, tempOk;
  logic         overcurrentFault, nvReloadDone, mapWrite, sampleReq, slow;
  logic         internalSupplyEn, nvReloadReq, fetEnable, loadCheckPassed, scanError;
  logic [7:0]   nvCellMap, mapWriteData, balanceRequest, cell_presence_map;
  logic [7:0]   balanceEnable, storedMap, expMap;
  logic [2:0]   cellSelect;
  logic [31:0]  rs = 32'hC551;
  supply_t      supplyLevels;
  cell_sample_t sample;
  seq_state_t   seqState;
  int           miscompares = 0, comparisons = 0, cyc = 0, seen[$];

  pack_power_up_sequencer #(.SCAN_CYC(SCAN), .SETTLE_CYC(SETTLE), .SAMPLE_CYC(SAMPLE))
    i_pack_power_up_sequencer (.mclk, .rst_b, .chargerMonitorInput, .loadMonitorInput,
    .supplyLevels, .sample, .tempOk, .overcurrentFault, .nvReloadDone, .nvCellMap,
    .mapWrite, .mapWriteData, .balanceRequest, .cell_presence_map, .balanceEnable,
    .cellSelect, .sampleReq, .internalSupplyEn, .nvReloadReq, .fetEnable,
    .loadCheckPassed, .scanError, .seqState);
  cell_stack_model i_cell_stack_model (.mclk, .slow, .fitted(8'h83), .cellSelect,
    .sampleReq, .nvReloadReq, .storedMap, .sample, .nvReloadDone, .nvCellMap);

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Cycle count and the list of cells actually measured
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (sampleReq === 1'b1 && sample.done === 1'b1)
      seen.push_back(cellSelect);
  end

  function logic [7:0] rnd8();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction

  function automatic logic [7:0] seen_mask();
    logic [7:0] m;
    m = 8'h00;
    foreach (seen[i]) m[seen[i]] = 1'b1;
    return m;
  endfunction

  task automatic check(input bit ok, input string what);
    comparisons++;
    if (!ok)
    begin
      miscompares++;
      $display("BAD %0t %s", $time, what);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Bounded wait; running out ends the run
  task automatic wait_state(input seq_state_t target, input int bound);
    int n;
    n = 0;
    while (seqState !== target && n < bound)
    begin
      cycles(1);
      n++;
    end
    if (n >= bound)
    begin
      miscompares++;
      $display("BAD %0t state wait timed out", $time);
      wrap_up();
    end
  endtask

  task automatic wrap_up();
    $display("counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    int t0, pc, n;
    {rst_b, chargerMonitorInput, loadMonitorInput, overcurrentFault, mapWrite, slow} = '0;
    {tempOk, supplyLevels, storedMap, mapWriteData, balanceRequest} = {4'hF, 8'h83, 16'h0};
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    cycles(20);
    check(seqState === ST_PWR_DOWN && internalSupplyEn === 1'b0, "not asleep");
    check(cell_presence_map === CELL_MAP_RESET, "map default");
    $display("test reset done");
    expMap = storedMap;
    @(posedge mclk) chargerMonitorInput <= 1'b1;
    wait_state(ST_POR_LOOP, 20);
    check(cell_presence_map === expMap, "map reload");
    seen.delete();
    wait_state(ST_LOAD_SAMP, 2 * SCAN + SETTLE + 10);
    check(seen_mask() === expMap, "cells scanned");
    @(posedge mclk) loadMonitorInput <= 1'b1;
    wait_state(ST_POR_LOOP, SAMPLE + 10);
    @(posedge mclk) loadMonitorInput <= 1'b0;
    wait_state(ST_LOAD_WAIT, 2 * SCAN);
    @(posedge mclk) tempOk <= 1'b0;
    wait_state(ST_POR_LOOP, 4);
    @(posedge mclk) tempOk <= 1'b1;
    wait_state(ST_LOAD_WAIT, 2 * SCAN);
    t0 = cyc;
    wait_state(ST_NORMAL, SETTLE + 3 * SAMPLE);
    n = cyc - t0 - SETTLE - 2 * SAMPLE;
    check(n >= -2 && n <= 4, "load check time");
    cycles(2);
    check(fetEnable === 1'b1 && loadCheckPassed === 1'b1, "fets on");
    repeat (8)
    begin
      @(posedge mclk) balanceRequest <= rnd8();
      cycles(1);
      check(balanceEnable === (balanceRequest & expMap), "balance gate");
    end
    for (int k = 0; k < 2; k++)
    begin
      @(posedge mclk) {overcurrentFault, tempOk} <= k ? 2'h0 : 2'h3;
      cycles(2);
      check(fetEnable === 1'b0, "fets off on fault");
      @(posedge mclk) {overcurrentFault, tempOk} <= 2'h1;
      cycles(3);
      check(fetEnable === 1'b1, "fets back");
    end
    $display("test power-up done");
    @(posedge mclk) supplyLevels <= 3'h5;
    cycles(10);
    check(seqState === ST_NORMAL && fetEnable === 1'b1, "stays on in dip");
    @(posedge mclk) supplyLevels <= 3'h4;
    cycles(6);
    check(seqState === ST_PWR_DOWN && internalSupplyEn === 1'b0, "power down");
    @(posedge mclk) chargerMonitorInput <= 1'b0;
    @(posedge mclk) supplyLevels <= 3'h7;
    cycles(20);
    check(seqState === ST_PWR_DOWN, "waits for charger");
    $display("test supply done");
    @(posedge mclk) storedMap <= rnd8() | 8'h87;
    @(posedge mclk) chargerMonitorInput <= 1'b1;
    slow <= 1'b1;
    expMap = storedMap;
    wait_state(ST_POR_LOOP, 20);
    check(cell_presence_map === expMap, "map reload");
    seen.delete();
    cycles(4 * SCAN);
    pc = $countones(expMap);
    check(seqState === ST_POR_LOOP && scanError === 1'b1 && !fetEnable, "held");
    check(balanceEnable === 8'h00, "no balance outside normal");
    check(seen_mask() === expMap, "scan uses map");
    check(seen.size() >= 3 * pc && seen.size() <= 5 * pc, "scan rate");
    for (n = 0; n < 300 && !(sampleReq === 1'b1 && cellSelect === 3'h7); n++) cycles(1);
    for (; n < 300 && sampleReq !== 1'b0; n++) cycles(1);
    check(n < 300, "scan end wait");
    if (n >= 300)
      wrap_up();
    @(posedge mclk) mapWrite <= 1'b1;
    mapWriteData <= 8'h83;
    @(posedge mclk) mapWrite <= 1'b0;
    expMap = 8'h83;
    wait_state(ST_NORMAL, 3 * SCAN + SETTLE + 3 * SAMPLE);
    check(cell_presence_map === expMap, "map write");
    @(posedge mclk) supplyLevels <= 3'h3;
    cycles(6);
    check(seqState === ST_PWR_DOWN, "1 V dip");
    $display("test missing cell done");
    wrap_up();
  end
endmodule

bind pack_power_up_sequencer pack_power_up_sequencer_asserts i_asserts (.mclk, .rst_b,
  .chargerMonitorInput, .loadMonitorInput, .supplyLevels, .sample, .tempOk,
  .overcurrentFault, .nvReloadDone, .nvCellMap, .mapWrite, .mapWriteData, .balanceRequest,
  .cell_presence_map, .balanceEnable, .cellSelect, .sampleReq, .internalSupplyEn,
  .nvReloadReq, .fetEnable, .loadCheckPassed, .scanError, .seqState);
